//--- rtl/ibec_top.sv
// boot entry control: service area, entry decision, flash guard
`timescale 1ns/10ps
`default_nettype none
`include "ibec_consts.svh"

module ibec_top #(
  parameter int POST_WIN = `IBEC_POST_WIN_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // hardware reset sources, asynchronous pins
  input  wire logic              por_req,
  input  wire logic              pad_rst_n,
  // straps and pulse pin
  input  wire logic              strap_pair_input_a,
  input  wire logic              strap_pair_input_b,
  input  wire logic              alternate_strap_input,
  input  wire logic              serial_receive_pulse_input,
  input  wire logic              prog_mode_pin,
  // core side, same clock
  input  wire logic [7:0]        flash_loc0_data,
  input  wire logic              core_jump_valid,
  input  wire logic [15:0]       core_jump_target,
  input  wire logic              core_power_down,
  input  wire logic              wdt_rst,
  output logic                   core_rst_hold,
  output logic                   pc_load,
  output logic [15:0]            pc_load_addr,
  output logic                   service_mode,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // flash array command port
  output logic                   fl_cmd_valid,
  output ibec_pkg::ibec_fcmd_s   fl_cmd,
  output logic                   fl_keep_en,
  output logic [15:0]            fl_keep_start,
  input  wire logic              fl_ack,
  output logic                   fcmd_done,
  // readout path
  input  wire logic              rd_valid,
  input  wire logic [7:0]        rd_data,
  output logic                   rd_out_valid,
  output logic [7:0]             rd_out_data
);

  // ============================================================
  // helpers

  // start address of the service area
  function automatic logic [15:0] svc_start(input logic [4:0] n);
    logic [16:0] s;
    s = `IBEC_ADDR_TOP - ({12'h000, n} << `IBEC_PAGE_SHIFT);
    return s[15:0];
  endfunction : svc_start

  // enable bit for a trigger at power-on or pad reset
  function automatic logic trig_en(input logic [7:0] en,
                                   input int idx,
                                   input logic por, input logic pad);
    return (en[2*idx] & por) | (en[2*idx+1] & pad);
  endfunction : trig_en

  // ============================================================
  // pin synchronisers

  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;

  assign pin_raw = {prog_mode_pin, alternate_strap_input,
                    strap_pair_input_b, strap_pair_input_a,
                    ~pad_rst_n, por_req};

  // straps idle high, reset requests idle low
  localparam logic [NPIN-1:0] PIN_IDLE = 6'h1c;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_s1_reg[gi] <= PIN_IDLE[gi];
          pin_s2_reg[gi] <= PIN_IDLE[gi];
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
        end
      end
    end
  endgenerate

  logic por_s, pad_s, str_a_s, str_b_s, alt_s, prog_s, hw_rst;
  assign por_s   = pin_s2_reg[0];
  assign pad_s   = pin_s2_reg[1];
  assign str_a_s = pin_s2_reg[2];
  assign str_b_s = pin_s2_reg[3];
  assign alt_s   = pin_s2_reg[4];
  assign prog_s  = pin_s2_reg[5];
  assign hw_rst  = por_s | pad_s;

  // ============================================================
  // configuration registers

  logic [4:0]  n_reg;
  logic        protect_reg;
  logic [7:0]  entry_en_reg;
  logic [15:0] faddr_reg;
  logic [7:0]  fdata_reg;
  logic [4:0]  n_wr;
  logic        locked;
  logic [15:0] start;
  logic        wr_cfg, wr_en, wr_cmd;

  assign wr_cfg = reg_wr && reg_addr == `IBEC_REG_CFG;
  assign wr_en  = reg_wr && reg_addr == `IBEC_REG_ENTRY_EN;
  assign wr_cmd = reg_wr && reg_addr == `IBEC_REG_FCMD;
  assign start  = svc_start(n_reg);
  assign locked = (n_reg != `IBEC_N_ZERO) && !prog_s;
  // clamp: beyond sixteen pages would eat user space
  assign n_wr = (reg_wdata[4:0] > `IBEC_N_MAX) ? `IBEC_N_MAX
                                               : reg_wdata[4:0];

  // size and protect: size only from the external programmer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      n_reg       <= `IBEC_N_ZERO;
      protect_reg <= 1'b0;
    end else begin
      if (wr_cfg && prog_s) begin
        n_reg <= n_wr;
      end
      if (prog_s && wr_cfg && !reg_wdata[`IBEC_CFG_PROT_BIT]) begin
        protect_reg <= 1'b0;
      end else if ((wr_cfg && reg_wdata[`IBEC_CFG_PROT_BIT]) ||
                   (wr_cmd && reg_wdata[2:0] == ibec_pkg::OP_PROTECT))
      begin
        protect_reg <= 1'b1;
      end
    end
  end

  // entry enables: option write from the programmer, or with a service area, unprotected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      entry_en_reg <= `IBEC_ENTRY_EN_RST;
    end else if (wr_en && (prog_s ||
                 (n_reg != `IBEC_N_ZERO && !protect_reg))) begin
      entry_en_reg <= reg_wdata[7:0];
    end
  end

  // flash address and data staging
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faddr_reg <= 16'hffff;
      fdata_reg <= 8'hff;
    end else begin
      if (reg_wr && reg_addr == `IBEC_REG_FADDR) begin
        faddr_reg <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `IBEC_REG_FDATA) begin
        fdata_reg <= reg_wdata[7:0];
      end
    end
  end

  // ============================================================
  // flash command guard

  ibec_pkg::ibec_op_e op_w;
  logic in_area, is_arr, suppress;

  assign op_w    = ibec_pkg::ibec_op_e'(reg_wdata[2:0]);
  assign in_area = (n_reg != `IBEC_N_ZERO) && (faddr_reg >= start);
  assign is_arr  = op_w == ibec_pkg::OP_PROG ||
                   op_w == ibec_pkg::OP_PAGE ||
                   op_w == ibec_pkg::OP_CHIP;
  // program or page erase into a locked area is dropped silently
  assign suppress = (op_w == ibec_pkg::OP_PROG ||
                     op_w == ibec_pkg::OP_PAGE) &&
                    in_area && locked;

  // issue to the array; everything else completes at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fl_cmd_valid <= 1'b0;
      fl_cmd       <= '0;
      fcmd_done    <= 1'b0;
    end else begin
      fl_cmd_valid <= wr_cmd && is_arr && !suppress;
      fcmd_done    <= fl_ack || (wr_cmd && !(is_arr && !suppress));
      if (wr_cmd) begin
        fl_cmd.op   <= op_w;
        fl_cmd.addr <= faddr_reg;
        fl_cmd.data <= fdata_reg;
      end
    end
  end

  // chip erase keeps everything from the area start upward while the area is locked
  assign fl_keep_en    = locked;
  assign fl_keep_start = start;

  // readout: protected parts answer zero everywhere
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_out_valid <= 1'b0;
      rd_out_data  <= `IBEC_PROT_BYTE;
    end else begin
      rd_out_valid <= rd_valid;
      rd_out_data  <= protect_reg ? `IBEC_PROT_BYTE : rd_data;
    end
  end

  // ============================================================
  // boot sequencer

  ibec_pkg::ibec_state_e state_reg;
  ibec_pkg::ibec_trig_s  flags_reg;
  logic        por_seen_reg, pad_seen_reg;
  logic        pair_low_reg, alt_low_reg, blank_reg;
  logic [15:0] win_reg;
  logic        pulse_met, pulse_en;
  logic [3:0]  hit;

  assign pulse_en = state_reg == ibec_pkg::ST_HOLD ||
                    state_reg == ibec_pkg::ST_WAIT;

  ibec_pulse_cnt #(
    .NEED (`IBEC_PULSES_NEED)
  ) u_pulse (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clear     (hw_rst && state_reg == ibec_pkg::ST_RUN),
    .enable    (pulse_en),
    .pin_in    (serial_receive_pulse_input),
    .count_met (pulse_met)
  );

  // per-mechanism hits, each gated by its reset source
  assign hit[0] = blank_reg    & trig_en(entry_en_reg, 0,
                  por_seen_reg, pad_seen_reg);
  assign hit[1] = pair_low_reg & trig_en(entry_en_reg, 1,
                  por_seen_reg, pad_seen_reg);
  assign hit[2] = alt_low_reg  & trig_en(entry_en_reg, 2,
                  por_seen_reg, pad_seen_reg);
  assign hit[3] = pulse_met    & trig_en(entry_en_reg, 3,
                  por_seen_reg, pad_seen_reg);

  // state walk: hold in reset, post window, decide, run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ibec_pkg::ST_HOLD;
    end else begin
      case (state_reg)
        ibec_pkg::ST_HOLD: begin
          if (!hw_rst) state_reg <= ibec_pkg::ST_WAIT;
        end
        ibec_pkg::ST_WAIT: begin
          if (hw_rst) state_reg <= ibec_pkg::ST_HOLD;
          else if (pulse_met || win_reg == 16'h0000)
            state_reg <= ibec_pkg::ST_DECIDE;
        end
        ibec_pkg::ST_DECIDE: state_reg <= ibec_pkg::ST_RUN;
        ibec_pkg::ST_RUN: begin
          if (hw_rst) state_reg <= ibec_pkg::ST_HOLD;
        end
        default: state_reg <= ibec_pkg::ST_HOLD;
      endcase
    end
  end

  // post-reset window for the second pulse
  always_ff @(posedge clk) begin
    if (sys_rst || state_reg != ibec_pkg::ST_WAIT) begin
      win_reg <= POST_WIN[15:0];
    end else if (win_reg != 16'h0000) begin
      win_reg <= win_reg - 16'h0001;
    end
  end

  // sample while in reset; straps and blank keep the last sample, the source flags accumulate in hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      por_seen_reg <= 1'b0;
      pad_seen_reg <= 1'b0;
      pair_low_reg <= 1'b0;
      alt_low_reg  <= 1'b0;
      blank_reg    <= 1'b0;
    end else if (hw_rst) begin
      if (state_reg != ibec_pkg::ST_HOLD) begin
        por_seen_reg <= por_s;
        pad_seen_reg <= pad_s;
      end else begin
        por_seen_reg <= por_seen_reg | por_s;
        pad_seen_reg <= pad_seen_reg | pad_s;
      end
      pair_low_reg <= !str_a_s && !str_b_s;
      alt_low_reg  <= !alt_s;
      blank_reg    <= flash_loc0_data == `IBEC_BLANK_BYTE;
    end
  end

  // entry flags: cleared by any reset, set once at the decision
  always_ff @(posedge clk) begin
    if (sys_rst || hw_rst || wdt_rst) begin
      flags_reg <= '0;
    end else if (state_reg == ibec_pkg::ST_DECIDE &&
                 n_reg != `IBEC_N_ZERO) begin
      flags_reg <= ibec_pkg::ibec_trig_s'(hit);
    end
  end

  // service mode and program counter load
  always_ff @(posedge clk) begin
    if (sys_rst || hw_rst) begin
      service_mode <= 1'b0;
      pc_load      <= 1'b0;
      pc_load_addr <= `IBEC_RESET_VEC;
    end else begin
      pc_load <= 1'b0;
      if (state_reg == ibec_pkg::ST_DECIDE) begin
        // any number of hits still means a single entry
        if (|hit && n_reg != `IBEC_N_ZERO) begin
          service_mode <= 1'b1;
          pc_load_addr <= start;
        end else begin
          pc_load_addr <= `IBEC_RESET_VEC;
        end
        pc_load <= 1'b1;
      end else if (state_reg == ibec_pkg::ST_RUN) begin
        if (wdt_rst) begin
          service_mode <= 1'b0;
          pc_load      <= 1'b1;
          pc_load_addr <= `IBEC_RESET_VEC;
        end else if (core_jump_valid) begin
          if (core_jump_target == `IBEC_RESET_VEC) begin
            service_mode <= 1'b0;
          end else if (core_jump_target == start &&
                       n_reg != `IBEC_N_ZERO &&
                       !core_power_down) begin
            service_mode <= 1'b1;
          end
        end
      end
    end
  end

  assign core_rst_hold = state_reg != ibec_pkg::ST_RUN;

  // ============================================================
  // register read, one cycle after the strobe

  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `IBEC_REG_CFG:
          reg_rdata <= {26'h0, protect_reg, n_reg};
        `IBEC_REG_ENTRY_EN:
          reg_rdata <= {24'h0, entry_en_reg};
        `IBEC_REG_STATUS:
          reg_rdata <= {24'h0,
                        state_reg == ibec_pkg::ST_RUN,
                        protect_reg, locked, service_mode,
                        flags_reg};
        `IBEC_REG_FADDR:
          reg_rdata <= {16'h0, faddr_reg};
        `IBEC_REG_FDATA:
          reg_rdata <= {24'h0, fdata_reg};
        `IBEC_REG_FCMD:
          reg_rdata <= {29'h0, fl_cmd.op};
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : ibec_top

`default_nettype wire

//--- rtl/ibec_consts.svh
// constants for the boot entry control block
`ifndef IBEC_CONSTS_SVH
`define IBEC_CONSTS_SVH

// ============================================================
// service area geometry
`define IBEC_N_W           5
`define IBEC_N_MAX         5'h10
`define IBEC_N_ZERO        5'h00
`define IBEC_ADDR_TOP      17'h10000
`define IBEC_PAGE_SHIFT    8
`define IBEC_RESET_VEC     16'h0000

// ============================================================
// flash data values
`define IBEC_BLANK_BYTE    8'hff
`define IBEC_PROT_BYTE     8'h00

// ============================================================
// timing
`define IBEC_CLK_NS        25
`define IBEC_POST_WIN_NS   10000
`define IBEC_POST_WIN_CYC  ((`IBEC_POST_WIN_NS+`IBEC_CLK_NS-1)/`IBEC_CLK_NS)
`define IBEC_PULSES_NEED   2

// ============================================================
// register offsets
`define IBEC_REG_CFG       8'h00
`define IBEC_REG_ENTRY_EN  8'h04
`define IBEC_REG_STATUS    8'h08
`define IBEC_REG_FADDR     8'h0c
`define IBEC_REG_FDATA     8'h10
`define IBEC_REG_FCMD      8'h14

// ============================================================
// field positions
`define IBEC_CFG_PROT_BIT  5
`define IBEC_ST_SVC_BIT    4
`define IBEC_ST_LOCK_BIT   5
`define IBEC_ST_PROT_BIT   6
`define IBEC_ST_RUN_BIT    7
`define IBEC_ENTRY_EN_RST  8'hff

`endif

//--- rtl/ibec_pkg.sv
// types shared by the boot entry control block
package ibec_pkg;

  // boot sequencer states
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_DECIDE = 2'b10,
    ST_RUN    = 2'b11
  } ibec_state_e;

  // flash command codes
  typedef enum logic [2:0] {
    OP_PROG    = 3'b000,
    OP_PROTECT = 3'b001,
    OP_PAGE    = 3'b010,
    OP_CHIP    = 3'b011,
    OP_OPT_WR  = 3'b100,
    OP_OPT_RD  = 3'b101,
    OP_OPT_ER  = 3'b110,
    OP_RSVD    = 3'b111
  } ibec_op_e;

  // flash command to the array
  typedef struct packed {
    ibec_op_e    op;
    logic [15:0] addr;
    logic [7:0]  data;
  } ibec_fcmd_s;

  // entry trigger conditions, one per mechanism
  typedef struct packed {
    logic pulse;
    logic alt;
    logic pair;
    logic blank;
  } ibec_trig_s;

endpackage : ibec_pkg

//--- rtl/ibec_pulse_cnt.sv
// counts rising edges on the serial receive pin
`timescale 1ns/10ps
`default_nettype none

module ibec_pulse_cnt #(
  parameter int NEED = 2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic clear,
  input  wire logic enable,
  // pin
  input  wire logic pin_in,
  // result
  output logic      count_met
);

  logic       sync1_reg;
  logic       sync2_reg;
  logic       prev_reg;
  logic [1:0] cnt_reg;

  // two flops before anything looks at the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // saturating edge counter, restarted by sys_rst or by a hardware reset that arrives in ST_RUN
  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      cnt_reg <= 2'h0;
    end else if (enable && sync2_reg && !prev_reg &&
                 cnt_reg != NEED[1:0]) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  assign count_met = (cnt_reg == NEED[1:0]);

endmodule : ibec_pulse_cnt

`default_nettype wire

//--- tb/ibec_top_assertions.sv
// checker on the ports of the boot entry control top
`timescale 1ns/10ps
`default_nettype none

module ibec_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // core side
  input wire logic        core_jump_valid,
  input wire logic [15:0] core_jump_target,
  input wire logic        core_power_down,
  input wire logic        core_rst_hold,
  input wire logic        pc_load,
  input wire logic [15:0] pc_load_addr,
  input wire logic        service_mode,
  // register, flash and readout side
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        fl_cmd_valid,
  input wire logic        fl_keep_en,
  input wire logic [15:0] fl_keep_start,
  input wire logic        fl_ack,
  input wire logic        fcmd_done,
  input wire logic        rd_valid,
  input wire logic        rd_out_valid
);
  // ==========================================================
  // properties, one clock domain only
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_vec_shape: assert property (pc_load && service_mode |->
    pc_load_addr[7:0] == 8'h00 && pc_load_addr[15:12] == 4'hf)
    else $error("service vector not on a page in the top area");
  a_hold_release: assert property ($fell(core_rst_hold) |-> pc_load)
    else $error("core released without a vector load");
  a_svc_cause: assert property ($rose(service_mode) |->
    pc_load || $past(core_jump_valid))
    else $error("service mode entered with no cause");
  a_jump_zero: assert property (core_jump_valid && !core_rst_hold &&
    core_jump_target == 16'h0000 |=> !service_mode)
    else $error("jump to zero left service mode set");
  a_pd_noentry: assert property (core_power_down && !service_mode
    |=> !service_mode)
    else $error("service mode entered in power down");
  a_keep_shape: assert property (fl_keep_en |->
    fl_keep_start[7:0] == 8'h00 && fl_keep_start[15:12] == 4'hf)
    else $error("kept area start out of the top area");
  a_cmd_pulse: assert property (fl_cmd_valid |=> !fl_cmd_valid)
    else $error("flash command valid longer than one cycle");
  a_done_ack: assert property (fl_ack |=> fcmd_done)
    else $error("no done after array acknowledge");
  a_rd_turn: assert property (rd_valid |=> rd_out_valid)
    else $error("readout not returned one cycle later");
  a_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0)
    else $error("read data outside the read answer cycle");
endmodule : ibec_chk

bind ibec_top ibec_chk i_ibec_chk (
  .clk(clk), .sys_rst(sys_rst), .core_jump_valid(core_jump_valid),
  .core_jump_target(core_jump_target), .core_power_down(core_power_down),
  .core_rst_hold(core_rst_hold), .pc_load(pc_load),
  .pc_load_addr(pc_load_addr), .service_mode(service_mode),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_cmd_valid(fl_cmd_valid),
  .fl_keep_en(fl_keep_en), .fl_keep_start(fl_keep_start),
  .fl_ack(fl_ack), .fcmd_done(fcmd_done), .rd_valid(rd_valid),
  .rd_out_valid(rd_out_valid)
);

`default_nettype wire

//--- tb/ibec_host_model.sv
// external host that drives the straps and the pulse pin
`timescale 1ns/10ps
`default_nettype none

module ibec_host_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic pair_low,
  input wire logic alt_low,
  input wire logic pulse_go,
  // strap and pulse pins
  output logic     strap_pair_input_a,
  output logic     strap_pair_input_b,
  output logic     alternate_strap_input,
  output logic     serial_receive_pulse_input
);
  logic [3:0] pulse_cnt = 4'h0;

  // ==========================================================
  // straps stay high unless entry is wanted
  assign strap_pair_input_a    = ~pair_low;
  assign strap_pair_input_b    = ~pair_low;
  assign alternate_strap_input = ~alt_low;

  // two low-high cycles of eight clocks, four low and four high, line idles high like a quiet rx
  always @(posedge clk) begin
    if (pulse_go) begin
      pulse_cnt <= 4'hf;
    end else if (pulse_cnt != 4'h0) begin
      pulse_cnt <= pulse_cnt - 4'h1;
    end
  end
  assign serial_receive_pulse_input = ~pulse_cnt[2];
endmodule : ibec_host_model

`default_nettype wire

//--- tb/test_isp_boot_entry_control.sv
// self-checking bench for the boot entry control block
`timescale 1ns/10ps
`default_nettype none

module test_isp_boot_entry_control;
  // design pins
  logic clk, sys_rst, por_req, pad_rst_n, prog_mode_pin;
  logic sp_a, sp_b, alt_s, ser, pair_low, alt_low, pulse_go;
  logic [7:0]  flash_loc0_data, reg_addr, rd_data, rd_out_data;
  logic [15:0] core_jump_target, pc_load_addr, fl_keep_start;
  logic [31:0] reg_wdata, reg_rdata;
  logic core_jump_valid, core_power_down, wdt_rst, core_rst_hold, pc_load;
  logic service_mode, reg_wr, reg_rd, fl_cmd_valid, fl_keep_en, fl_ack;
  logic fcmd_done, rd_valid, rd_out_valid;
  ibec_pkg::ibec_fcmd_s fl_cmd;
  int fail_count, cmp_count, cyc, pl_cnt;
  int sz[3] = '{16, 8, 1}; // service area sizes in pages

  ibec_top #(.POST_WIN(20)) i_ibec_top (
    .clk(clk), .sys_rst(sys_rst), .por_req(por_req), .pad_rst_n(pad_rst_n),
    .strap_pair_input_a(sp_a), .strap_pair_input_b(sp_b),
    .alternate_strap_input(alt_s), .serial_receive_pulse_input(ser),
    .prog_mode_pin(prog_mode_pin), .flash_loc0_data(flash_loc0_data),
    .core_jump_valid(core_jump_valid), .core_jump_target(core_jump_target),
    .core_power_down(core_power_down), .wdt_rst(wdt_rst),
    .core_rst_hold(core_rst_hold), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .service_mode(service_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_cmd_valid(fl_cmd_valid),
    .fl_cmd(fl_cmd), .fl_keep_en(fl_keep_en), .fl_keep_start(fl_keep_start),
    .fl_ack(fl_ack), .fcmd_done(fcmd_done), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_out_valid(rd_out_valid), .rd_out_data(rd_out_data));

  ibec_host_model i_ibec_host_model (
    .clk(clk), .pair_low(pair_low), .alt_low(alt_low), .pulse_go(pulse_go),
    .strap_pair_input_a(sp_a), .strap_pair_input_b(sp_b),
    .alternate_strap_input(alt_s), .serial_receive_pulse_input(ser));

  // ==========================================================
  // clock, vector load count and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pc_load === 1'b1) pl_cnt <= pl_cnt + 1;
    if (cyc == 8000) begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================
  // access tasks and comparison
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, "register read");
  endtask : rchk

  // hardware reset with triggers t: blank, pair, alternate, pulses
  task automatic boot(input logic por, pad, input logic [3:0] t,
                      input logic [15:0] addr, input logic [7:0] st);
    int base;
    logic [15:0] got;
    base = pl_cnt;
    got = 16'hxxxx;
    @(posedge clk);
    por_req <= por;
    pad_rst_n <= !pad;
    flash_loc0_data <= t[0] ? 8'hff : 8'h00;
    pair_low <= t[1];
    alt_low <= t[2];
    pulse_go <= t[3];
    @(posedge clk);
    pulse_go <= 1'b0;
    repeat (8) @(posedge clk);
    por_req <= 1'b0;
    pad_rst_n <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (pc_load === 1'b1) begin
        got = pc_load_addr;
        break;
      end
    end
    repeat (6) @(posedge clk);
    pair_low <= 1'b0; // later strap changes must not matter
    alt_low <= 1'b0;
    flash_loc0_data <= 8'h00;
    chk(got, addr, "boot vector");
    chk(service_mode, addr != 16'h0, "service mode");
    chk(32'(pl_cnt - base), 1, "vector loads");
    rchk(8'h08, st);
  endtask : boot

  task automatic jmp(input logic [15:0] t, input logic pd, exp);
    @(posedge clk);
    core_jump_valid <= 1'b1;
    core_jump_target <= t;
    core_power_down <= pd;
    @(posedge clk);
    core_jump_valid <= 1'b0;
    core_power_down <= 1'b0;
    #1 chk(service_mode, exp, "mode after jump");
  endtask : jmp

  task automatic fl(input logic [2:0] op, input logic go);
    wr(8'h14, {29'h0, op});
    #1 chk(fl_cmd_valid, go, "command valid");
    chk(fcmd_done, !go, "done at once");
    if (go) begin
      @(posedge clk);
      fl_ack <= 1'b1;
      @(posedge clk);
      fl_ack <= 1'b0;
      #1 chk(fcmd_done, 1, "done after ack");
    end
  endtask : fl

  task automatic rdo(input logic [7:0] d, exp);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_data <= d;
    @(posedge clk);
    rd_valid <= 1'b0;
    #1 chk(rd_out_data, exp, "readout");
  endtask : rdo

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // main sequence
  initial begin
    {clk, por_req, prog_mode_pin, pair_low, alt_low, pulse_go} = '0;
    {core_jump_valid, core_power_down, wdt_rst, reg_wr, reg_rd} = '0;
    {fl_ack, rd_valid, reg_addr, reg_wdata, rd_data} = '0;
    {flash_loc0_data, core_jump_target, fail_count, cmp_count} = '0;
    {cyc, pl_cnt} = '0;
    pad_rst_n = 1'b1;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'hff);
    rchk(8'h20, 32'h0);
    boot(1, 0, 4'h1, 16'h0000, 8'h80);
    $display("test reset and empty area done");
    // area size steps, clamp and placement at the top
    // programmer pin crosses two sync flops before a size write lands
    @(posedge clk) prog_mode_pin <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'h00, 32'h14);
    rchk(8'h00, 32'h10);
    foreach (sz[j]) begin
      @(posedge clk) prog_mode_pin <= 1'b1;
      repeat (3) @(posedge clk);
      wr(8'h00, sz[j]);
      @(posedge clk) prog_mode_pin <= 1'b0;
      repeat (3) @(posedge clk);
      boot(1, 0, 4'h4, 16'(17'h10000 - sz[j] * 256), 8'hb4);
    end
    wr(8'h00, 32'h2);
    rchk(8'h00, 32'h1);
    $display("test area size done");
    // each of eight conditions fires only with its own reset source
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 32'h1 << i);
      boot(!i[0], i[0], 4'h1 << (i / 2), 16'hff00,
           8'hb0 | (8'h1 << (i / 2)));
      boot(i[0], !i[0], 4'h1 << (i / 2), 16'h0000, 8'ha0);
    end
    wr(8'h04, 32'hff);
    boot(1, 1, 4'hf, 16'hff00, 8'hbf);
    boot(0, 1, 4'h0, 16'h0000, 8'ha0);
    $display("test entry conditions done");
    // jumps, power down and watchdog
    jmp(16'hff00, 1, 0);
    jmp(16'hff00, 0, 1);
    jmp(16'h0000, 0, 0);
    jmp(16'hff00, 0, 1);
    @(posedge clk) wdt_rst <= 1'b1;
    @(posedge clk) wdt_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(service_mode, 0, "mode after watchdog");
    $display("test jumps done");
    // flash guard, erase scope and protection
    wr(8'h0c, 32'hff80);
    fl(3'h0, 0);
    fl(3'h2, 0);
    wr(8'h0c, 32'h1000);
    wr(8'h10, 32'h22);
    fl(3'h0, 1);
    chk(fl_cmd, {ibec_pkg::OP_PROG, 16'h1000, 8'h22}, "command");
    fl(3'h3, 1);
    chk(fl_keep_en, 1, "keep enable");
    chk(fl_keep_start, 16'hff00, "keep start");
    rdo(8'h5a, 8'h5a);
    fl(3'h1, 0);
    rdo(8'h5a, 8'h00);
    wr(8'h04, 32'h0);
    rchk(8'h04, 32'hff);
    // only with the programmer attached may the area be erased
    @(posedge clk) prog_mode_pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk(fl_keep_en, 0, "keep enable with programmer");
    $display("test flash guard done");
    complete_run();
  end
endmodule : test_isp_boot_entry_control

`default_nettype wire
